// ### pwpg_ctrl.sv
// pwpg_ctrl: access_controller write-protect state for analog, timer,
// serial and event units, with clear and set registers
// assumes one-cycle strobes, never both at once, read data one cycle later
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps

module pwpg_ctrl #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,    // system clock
    input  wire logic              rstn,       // async reset, active low
    input  wire logic [ADDR_W-1:0] regAddr,    // byte address
    input  wire logic [31:0]       regWdata,   // write data
    input  wire logic              regWr,      // write strobe
    input  wire logic              regRd,      // read strobe
    output logic [31:0]            regRdata,   // read data, cycle after strobe
    output pwpg_pkg::pwpg_prot_t   protFlags   // per-peripheral protected
);
    // offsets 0x00 and 0x04 need three address bits, decode sees eight
    if (ADDR_W < 3 || ADDR_W > 8) begin : g_addr_w_check
        $error("pwpg_ctrl: ADDR_W must be 3 to 8");
    end

    // exact match of one register offset
    function automatic logic offsetHit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return (addr == ofs);
    endfunction

    // only bits with a peripheral behind them, plus bit 23, are stored
    function automatic logic [31:0] storable(
        input logic [31:0] data
    );
        return data & pwpg_pkg::PROT_MASK;
    endfunction

    // per-peripheral flags picked out of the state word
    function automatic pwpg_pkg::pwpg_prot_t flagsOf(
        input logic [31:0] state
    );
        pwpg_pkg::pwpg_prot_t f;
        f.event_router_bit    = state[pwpg_pkg::EVENT_POS];
        f.serial_unit_bits    = state[pwpg_pkg::SERIAL_LO +: pwpg_pkg::SERIAL_N];
        f.timer_unit_bits     = state[pwpg_pkg::TIMER_LO +: pwpg_pkg::TIMER_N];
        f.adc_unit_bit        = state[pwpg_pkg::ADC_POS];
        f.comparator_unit_bit = state[pwpg_pkg::COMPARATOR_POS];
        f.dac_unit_bit        = state[pwpg_pkg::DAC_POS];
        f.touch_unit_bit      = state[pwpg_pkg::TOUCH_POS];
        return f;
    endfunction

    logic [31:0]          prot_r;
    logic [31:0]          prot_nxt;
    logic [31:0]          rdata_r;
    logic [31:0]          rdata_nxt;
    pwpg_pkg::pwpg_prot_t flags_r;
    pwpg_pkg::pwpg_prot_t flags_nxt;
    logic                 first_r;
    pwpg_pkg::pwpg_req_t  req;
    logic                 hitClear;
    logic                 hitSet;

    // request bundle: address widened to decode width, data, strobes
    assign req      = {8'(regAddr), regWdata, regWr, regRd};
    assign hitClear = offsetHit(req.addr, pwpg_pkg::OFS_CLEAR);
    assign hitSet   = offsetHit(req.addr, pwpg_pkg::OFS_SET);

    always_comb begin
        prot_nxt  = prot_r;
        rdata_nxt = '0;
        if (req.wr && hitClear) begin
            prot_nxt = prot_r & ~storable(req.wdata);
        end
        if (req.wr && hitSet) begin
            prot_nxt = prot_r | storable(req.wdata);
        end
        if (req.rd && (hitClear || hitSet)) begin
            rdata_nxt = prot_r;
        end
        // flags move on the same edge as the state
        flags_nxt = flagsOf(prot_nxt);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prot_r  <= pwpg_pkg::PROT_RESET;
            rdata_r <= '0;
            flags_r <= '0;
            first_r <= 1'h1;
        end else begin
            prot_r  <= prot_nxt;
            rdata_r <= rdata_nxt;
            flags_r <= flags_nxt;
            first_r <= 1'h0;
        end
    end

    assign regRdata  = rdata_r;
    assign protFlags = flags_r;

    a_zero_write_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        regWr |=> ((prot_r & ~$past(regWdata)) == ($past(prot_r) & ~$past(regWdata))))
        else $error("zero write changed protection");

    a_clear_removes: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitClear) |=> ((prot_r & $past(regWdata)) == 32'h00000000))
        else $error("clear did not remove protection");

    a_set_enables: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitSet) |=> ((prot_r & $past(regWdata) & pwpg_pkg::PROT_MASK)
                               == ($past(regWdata) & pwpg_pkg::PROT_MASK)))
        else $error("set did not enable protection");

    a_read_state: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regRd && (hitClear || hitSet)) |=> (regRdata == $past(prot_r)))
        else $error("read data differs from protection state");

    a_read_unmapped: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(regRd && (hitClear || hitSet)) |=> (regRdata == 32'h00000000))
        else $error("read data not zero without mapped read");

    a_timer_map: assert property (@(posedge ref_clk) disable iff (!rstn)
        protFlags.timer_unit_bits == prot_r[15:8])
        else $error("timer flags misplaced");

    a_serial_map: assert property (@(posedge ref_clk) disable iff (!rstn)
        protFlags.serial_unit_bits == prot_r[7:2])
        else $error("serial flags misplaced");

    a_reset_value: assert property (@(posedge ref_clk) disable iff (!rstn)
        first_r |-> (prot_r == 32'h00800000))
        else $error("wrong reset protection value");

    a_analog_map: assert property (@(posedge ref_clk) disable iff (!rstn)
        !first_r |-> ({protFlags.touch_unit_bit, protFlags.dac_unit_bit,
                       protFlags.comparator_unit_bit, protFlags.adc_unit_bit,
                       protFlags.event_router_bit}
                      == {prot_r[19:16], prot_r[1]}))
        else $error("analog or event flag misplaced");

    a_idle_stable: assert property (@(posedge ref_clk) disable iff (!rstn)
        !regWr |=> $stable(prot_r))
        else $error("protection changed without write");

    a_clear_only_drops: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitClear) |=> ((prot_r & ~$past(prot_r)) == 32'h00000000))
        else $error("clear raised a protection bit");

    a_set_only_adds: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitSet) |=> (($past(prot_r) & ~prot_r) == 32'h00000000))
        else $error("set dropped a protection bit");

    a_unmapped_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && !hitClear && !hitSet) |=> $stable(prot_r))
        else $error("unmapped write changed protection");

    a_read_keeps: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regRd && !regWr) |=> $stable(prot_r))
        else $error("read changed protection");

    a_read_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regRdata != 32'h00000000) |-> $past(regRd))
        else $error("read data without read strobe");

    a_unused_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        (prot_r & ~pwpg_pkg::PROT_MASK) == 32'h00000000)
        else $error("unused protection bit set");

    a_flags_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        !regWr |=> $stable(protFlags))
        else $error("flags changed without write");

    a_reset_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
        first_r |-> (protFlags == 19'h00000))
        else $error("flag protected after reset");

    a_timer_low_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitSet && regWdata[8]) |=> protFlags.timer_unit_bits[0])
        else $error("timer zero not protected by bit eight");

    a_timer_high_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitClear && regWdata[15]) |=> !protFlags.timer_unit_bits[7])
        else $error("timer seven not released by bit fifteen");

    a_serial_low_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitSet && regWdata[2]) |=> protFlags.serial_unit_bits[0])
        else $error("serial zero not protected by bit two");

    a_serial_high_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitClear && regWdata[7]) |=> !protFlags.serial_unit_bits[5])
        else $error("serial five not released by bit seven");

    a_event_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitSet && regWdata[1]) |=> protFlags.event_router_bit)
        else $error("event router not protected by bit one");

    a_adc_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitSet && regWdata[16]) |=> protFlags.adc_unit_bit)
        else $error("converter not protected by bit sixteen");

    a_touch_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitClear && regWdata[19]) |=> !protFlags.touch_unit_bit)
        else $error("touch unit not released by bit nineteen");

    a_dac_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        (regWr && hitSet && regWdata[18]) |=> protFlags.dac_unit_bit)
        else $error("output converter not protected by bit eighteen");
endmodule // pwpg_ctrl

// ### pwpg_pkg.sv
// pwpg_pkg: offsets, bit layout and reset values of the write-protect group
// assumes a 32-bit register port with byte addresses
package pwpg_pkg;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  OFS_CLEAR       = 8'h00;
    localparam logic [7:0]  OFS_SET         = 8'h04;
    localparam logic [31:0] PROT_RESET      = 32'h00800000;
    localparam logic [31:0] PROT_MASK       = 32'h008ffffe;
    localparam int          EVENT_POS       = 1;
    localparam int          SERIAL_LO       = 2;
    localparam int          SERIAL_N        = 6;
    localparam int          TIMER_LO        = 8;
    localparam int          TIMER_N         = 8;
    localparam int          ADC_POS         = 16;
    localparam int          COMPARATOR_POS  = 17;
    localparam int          DAC_POS         = 18;
    localparam int          TOUCH_POS       = 19;

    // per-peripheral protected flags
    typedef struct packed {
        logic       touch_unit_bit;
        logic       dac_unit_bit;
        logic       comparator_unit_bit;
        logic       adc_unit_bit;
        logic [7:0] timer_unit_bits;
        logic [5:0] serial_unit_bits;
        logic       event_router_bit;
    } pwpg_prot_t;

    // one register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pwpg_req_t;
endpackage

// ### pwpg_ctrl_bench.sv
// pwpg_ctrl_bench: self-checking bench for the write-protect group controller
// assumes pwpg_pkg is compiled first; the bench acts as register port master
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module pwpg_ctrl_bench;
    logic                 ref_clk, rstn, regWr, regRd;
    logic [7:0]           regAddr;
    logic [31:0]          regWdata, regRdata, m, r;
    pwpg_pkg::pwpg_prot_t protFlags;
    int                   checks, miscompares;

    pwpg_ctrl #(.ADDR_W(8)) DUT (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .protFlags(protFlags));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // model follows every accepted write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1; regRd <= 1'b0;
        if (a == pwpg_pkg::OFS_SET) m = m | (d & pwpg_pkg::PROT_MASK);
        else if (a == pwpg_pkg::OFS_CLEAR) m = m & ~(d & pwpg_pkg::PROT_MASK);
    endtask

    // read strobe, data only in the next cycle
    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        e = (a == pwpg_pkg::OFS_SET || a == pwpg_pkg::OFS_CLEAR) ? m : 32'h00000000;
        @(posedge ref_clk);
        regAddr <= a; regWr <= 1'b0; regRd <= 1'b1;
        #1 `CHK(regRdata, 32'h00000000)
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 `CHK(regRdata, e)
        `CHK(protFlags, m[19:1])
        `CHK(protFlags.timer_unit_bits, m[15:8])
        `CHK(protFlags.serial_unit_bits, m[7:2])
    endtask

    task automatic conclude();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        rstn = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWdata = 32'h00000000;
        checks = 0; miscompares = 0; m = pwpg_pkg::PROT_RESET;
        void'($urandom(18));
        repeat (20) @(posedge ref_clk);
        #1 `CHK(protFlags, 19'h00000)
        @(posedge ref_clk) rstn <= 1'h1;
        rd(pwpg_pkg::OFS_CLEAR);
        rd(pwpg_pkg::OFS_SET);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            wr(pwpg_pkg::OFS_SET, 32'h00000001 << i);
            rd(pwpg_pkg::OFS_CLEAR);
            wr(pwpg_pkg::OFS_CLEAR, 32'h00000001 << i);
            rd(pwpg_pkg::OFS_SET);
        end
        $display("test walking done");
        wr(pwpg_pkg::OFS_SET, 32'hffffffff);
        wr(pwpg_pkg::OFS_CLEAR, 32'h00000000);
        wr(pwpg_pkg::OFS_SET, 32'h00000000);
        rd(pwpg_pkg::OFS_CLEAR);
        $display("test zero done");
        for (int k = 0; k < 60; k++) begin
            r = $urandom;
            wr((r[1:0] == 2'h0) ? pwpg_pkg::OFS_CLEAR : (r[1:0] == 2'h1) ?
               pwpg_pkg::OFS_SET : r[15:8], $urandom);
            rd(r[17:16] == 2'h3 ? r[31:24] : {5'h00, r[18], 2'h0});
        end
        $display("test random done");
        conclude();
    end
endmodule // pwpg_ctrl_bench
